/* design/hidp_host_port.sv */
// Host memory DMA port: pin synchronisers, latch, transfer engine, memory side
`timescale 1ns/10ps
module hidp_host_port
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  // Host pins
  input wire logic i_port_select_n,
  input wire logic i_addr_latch_strobe,
  input wire logic i_host_read_strobe_n,
  input wire logic i_host_write_strobe_n,
  input wire logic [15:0] i_muxed_addr_data_bus,
  output logic [15:0] o_muxed_addr_data_bus,
  output logic o_muxed_addr_data_bus_oe,
  output logic o_host_ack_n,
  // Boot configuration pins C, B, A
  input wire logic [2:0] i_boot_mode,
  // Processor register access
  input wire logic i_dsp_reg_wr,
  input wire logic [13:0] i_dsp_reg_addr,
  input wire logic [15:0] i_dsp_reg_wdata,
  output logic [15:0] o_dsp_reg_rdata,
  // Internal memory access, granted in a stolen cycle
  output logic o_mem_req,
  output logic o_mem_we,
  output logic o_mem_is_data,
  output logic [13:0] o_mem_addr,
  output logic [7:0] o_mem_overlay,
  output logic [23:0] o_mem_wdata,
  input wire logic [23:0] i_mem_rdata,
  output logic o_proc_stall,
  output logic o_exec_hold
);
  // Two-flop synchronisers for every host pin
  logic [19:0] pin_meta_ff;
  logic [19:0] pin_sync_ff;
  logic [19:0] pin_prev_ff;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      // Idle pin levels: bus low, latch low, select and strobes high
      pin_meta_ff <= 20'h00007;
      pin_sync_ff <= 20'h00007;
      pin_prev_ff <= 20'h00007;
    end
    else
    begin
      pin_meta_ff <= {i_muxed_addr_data_bus, i_addr_latch_strobe, i_port_select_n,
        i_host_read_strobe_n, i_host_write_strobe_n};
      pin_sync_ff <= pin_meta_ff;
      pin_prev_ff <= pin_sync_ff;
    end
  end

  logic [15:0] bus_s;
  logic sel_s;
  logic latch_s;
  logic latch_fall;
  logic rd_s;
  logic wr_s;
  logic rd_start;
  logic wr_start;
  assign bus_s = pin_sync_ff[19:4];
  assign latch_s = pin_sync_ff[3];
  assign sel_s = ~pin_sync_ff[2];
  assign rd_s = ~pin_sync_ff[1];
  assign wr_s = ~pin_sync_ff[0];
  // Latch value taken where the strobe falls while selected
  assign latch_fall = pin_prev_ff[3] & ~latch_s & sel_s;
  assign rd_start = sel_s & rd_s & ~(~pin_prev_ff[2] & ~pin_prev_ff[1]);
  assign wr_start = sel_s & wr_s & ~(~pin_prev_ff[2] & ~pin_prev_ff[0]);

  hidp_pkg::hidp_state_t state_ff;
  hidp_pkg::hidp_state_t nxt_state;
  logic is_write_ff;
  logic [15:0] start_addr_ff;
  logic [15:0] overlay_ff;
  logic [15:0] hi_word_ff;
  logic word_half_ff;
  logic [15:0] wr_data_ff;

  // Transfer engine: one sync cycle, one access cycle, then done
  // A strobe seen in any state but idle is ignored until it is released
  always_comb
  begin
    nxt_state = state_ff;
    unique case (state_ff)
      hidp_pkg::ST_IDLE:
      begin
        // New strobe edge seen through the synchronisers
        if (rd_start || wr_start)
        begin
          nxt_state = hidp_pkg::ST_SYNC;
        end
      end
      hidp_pkg::ST_SYNC:
      begin
        nxt_state = hidp_pkg::ST_ACCESS;
      end
      hidp_pkg::ST_ACCESS:
      begin
        nxt_state = hidp_pkg::ST_DONE;
      end
      hidp_pkg::ST_DONE:
      begin
        nxt_state = hidp_pkg::ST_WAIT_REL;
      end
      hidp_pkg::ST_WAIT_REL:
      begin
        // Hold here until the host lets go of the strobe
        if (!(sel_s && (rd_s || wr_s)))
        begin
          nxt_state = hidp_pkg::ST_IDLE;
        end
      end
      default:
      begin
        nxt_state = hidp_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      state_ff <= hidp_pkg::ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  // Direction and write data captured at the start of a transaction
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      is_write_ff <= 1'b0;
      wr_data_ff <= 16'h0000;
    end
    else if (state_ff == hidp_pkg::ST_IDLE && (rd_start || wr_start))
    begin
      is_write_ff <= wr_start;
      wr_data_ff <= bus_s;
    end
  end

  logic mem_cycle;
  logic is_data;
  logic pm_second;
  assign mem_cycle = (state_ff == hidp_pkg::ST_ACCESS);
  assign is_data = start_addr_ff[hidp_pkg::BIT_MEM_TYPE];
  // Program words move as two bus words: upper 16 bits, then low byte
  assign pm_second = ~is_data & word_half_ff;
  logic real_access;
  assign real_access = mem_cycle & (is_data | pm_second | ~is_write_ff);

  // Start address and overlay registers, host latch or processor write
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      start_addr_ff <= hidp_pkg::RST_START_ADDR;
      overlay_ff <= hidp_pkg::RST_OVERLAY;
      word_half_ff <= 1'b0;
    end
    else if (latch_fall)
    begin
      word_half_ff <= 1'b0;
      if (bus_s[hidp_pkg::BIT_OVERLAY_SEL])
        overlay_ff <= {8'h00, bus_s[7:0]};
      else
        // Bit 14 keeps the memory type beside the 14-bit address
        start_addr_ff <= {1'b0, bus_s[14:0]};
    end
    else if (i_dsp_reg_wr && i_dsp_reg_addr == hidp_pkg::ADDR_START_REG)
    begin
      start_addr_ff <= {1'b0, i_dsp_reg_wdata[14:0]};
      word_half_ff <= 1'b0;
    end
    else if (i_dsp_reg_wr && i_dsp_reg_addr == hidp_pkg::ADDR_OVERLAY_REG)
    begin
      overlay_ff <= {8'h00, i_dsp_reg_wdata[7:0]};
    end
    else if (mem_cycle)
    begin
      if (is_data || pm_second)
      begin
        start_addr_ff[13:0] <= start_addr_ff[13:0] + 14'h0001;
        word_half_ff <= 1'b0;
      end
      else
        word_half_ff <= 1'b1;
    end
  end

  // First bus word of a program write (bits 23:8) held until the low byte arrives
  // Reads need no copy: each half is taken from memory in its own cycle
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      hi_word_ff <= 16'h0000;
    else if (mem_cycle && is_write_ff && !is_data && !word_half_ff)
      hi_word_ff <= wr_data_ff;
  end

  // Memory request for one stolen processor cycle
  // Control space writes keep their pulse but lose the write enable
  logic ctrl_hit;
  assign ctrl_hit = is_data && (start_addr_ff[13:0] >= hidp_pkg::ADDR_CTRL_LOW);
  assign o_mem_req = real_access;
  assign o_mem_we = real_access & is_write_ff & ~ctrl_hit;
  assign o_proc_stall = real_access;
  assign o_mem_is_data = is_data;
  assign o_mem_addr = start_addr_ff[13:0];
  assign o_mem_overlay = overlay_ff[7:0];

  // Memory write word: data words as they are, program words from both halves
  always_comb
  begin
    if (is_data)
    begin
      o_mem_wdata = {8'h00, wr_data_ff};
    end
    else
    begin
      o_mem_wdata = {hi_word_ff, wr_data_ff[7:0]};
    end
  end

  // Read data registered and driven back while the host reads
  // Program reads give bits 23:8 first, then the low byte
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_muxed_addr_data_bus <= 16'h0000;
    else if (mem_cycle && !is_write_ff)
      o_muxed_addr_data_bus <= is_data ? i_mem_rdata[15:0]
        : (pm_second ? {8'h00, i_mem_rdata[7:0]} : i_mem_rdata[23:8]);
  end
  // Only memory data is ever driven; the latched address has no read path
  assign o_muxed_addr_data_bus_oe = sel_s & rd_s & ~is_write_ff
    & (state_ff == hidp_pkg::ST_DONE || state_ff == hidp_pkg::ST_WAIT_REL);

  // Acknowledge low only when the port can take the next cycle
  // It drops once the access is done, even while the strobe is still held
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
      o_host_ack_n <= 1'b1;
    else
      o_host_ack_n <= ~(nxt_state == hidp_pkg::ST_IDLE
        || nxt_state == hidp_pkg::ST_WAIT_REL);
  end

  // Processor register read-back, both registers whole
  always_comb
  begin
    if (i_dsp_reg_addr == hidp_pkg::ADDR_OVERLAY_REG)
    begin
      o_dsp_reg_rdata = overlay_ff;
    end
    else if (i_dsp_reg_addr == hidp_pkg::ADDR_START_REG)
    begin
      o_dsp_reg_rdata = start_addr_ff;
    end
    else
    begin
      o_dsp_reg_rdata = 16'h0000;
    end
  end

  // Boot pins pass two flops that run through reset, so the value is ready at release
  // The pins must stand steady for two clocks before reset is released
  logic [2:0] boot_meta_ff;
  logic [2:0] boot_sync_ff;
  always_ff @(posedge i_clk_sys)
  begin
    boot_meta_ff <= i_boot_mode;
    boot_sync_ff <= boot_meta_ff;
  end

  // Boot mode taken on the first clock after reset release
  logic boot_taken_ff;
  always_ff @(posedge i_clk_sys or negedge i_resetn)
  begin
    if (!i_resetn)
    begin
      boot_taken_ff <= 1'b0;
      o_exec_hold <= 1'b1;
    end
    else if (!boot_taken_ff)
    begin
      boot_taken_ff <= 1'b1;
      o_exec_hold <= (boot_sync_ff == hidp_pkg::BOOT_MODE_HOST);
    end
    else if (real_access && is_write_ff && !is_data && pm_second
      && start_addr_ff[13:0] == 14'h0000)
      o_exec_hold <= 1'b0;
  end
endmodule

/* pkg/hidp_pkg.sv */
// Constants for the host internal memory DMA port
// Summary of operation
// - One DSP cycle stolen per word, program reads one per half
// - Control registers are never host writable
// - Bit15 high latches overlay, bits14-8 zero
// - Bit15 low: 14-bit address, bit14 memory
// - 16-bit bus carries 24-bit program words
// - Strobes asynchronous, processor keeps running
// - Address advances after each data word or program low byte
// - Latch carries address and memory type
// - Address captured on latch strobe fall
// - Select plus latch loads control register
// - One sync cycle, then one access cycle
// - Address at 0x3fe0, overlay at 0x3fe7
// - Host cannot read back start address
// - DSP software writes start address directly
// - Boot pins C1 B0 A1 select host boot
// - Hold execution until program word 0 written
package hidp_pkg;
  localparam logic [13:0] ADDR_START_REG = 14'h3fe0;
  localparam logic [13:0] ADDR_OVERLAY_REG = 14'h3fe7;
  localparam logic [13:0] ADDR_CTRL_LOW = 14'h3fe0;
  localparam int BIT_OVERLAY_SEL = 15;
  localparam int BIT_MEM_TYPE = 14;
  localparam logic [15:0] RST_START_ADDR = 16'h0000;
  localparam logic [15:0] RST_OVERLAY = 16'h0000;
  localparam logic [2:0] BOOT_MODE_HOST = 3'h5;
  localparam int SYNC_CYCLES = 1;
  localparam int ACCESS_CYCLES = 1;
  typedef enum logic [4:0]
  {
    ST_IDLE = 5'h01,
    ST_SYNC = 5'h02,
    ST_ACCESS = 5'h04,
    ST_DONE = 5'h08,
    ST_WAIT_REL = 5'h10
  } hidp_state_t;
endpackage

/* verification/hidp_host_model.sv */
// Host processor model driving the port pins
`timescale 1ns/10ps
module hidp_host_model
(
  input wire logic i_clk_sys,
  input wire logic i_ack_n,
  input wire logic i_dut_oe,
  input wire logic [15:0] i_dut_bus,
  output logic o_sel_n,
  output logic o_ale,
  output logic o_rd_n,
  output logic o_wr_n,
  output logic [15:0] o_bus
);
  bit hung = 0;
  logic drv;
  logic [15:0] val;
  logic [15:0] last = 16'h0;
  // Undriven bus shows a changing pattern, not the last value
  assign o_bus = i_dut_oe ? i_dut_bus : (drv ? val : ~last);
  always_ff @(posedge i_clk_sys) last <= o_bus;
  initial {drv, val, o_sel_n, o_ale, o_rd_n, o_wr_n} = {17'h0, 4'hb};
  task automatic tick(input int k);
    repeat (k) @(posedge i_clk_sys);
    #5;
  endtask
  // Wait until the port shows ready
  task automatic wait_rdy();
    for (int i = 0; i < 20 && i_ack_n !== 1'b0; i++) tick(1);
    hung = hung | (i_ack_n !== 1'b0);
  endtask
  // Address or overlay latch, value taken at the strobe fall
  task automatic latch(input logic [15:0] a);
    wait_rdy();
    {drv, val, o_sel_n, o_ale} = {1'b1, a, 2'b01};
    tick(3);
    o_ale = 1'b0;
    tick(3);
    {drv, o_sel_n} = 2'b01;
    tick(1);
  endtask
  // One word transfer, held until the access is done
  task automatic xfer(input bit wr, input logic [15:0] d, output logic [15:0] q);
    wait_rdy();
    {drv, val, o_sel_n, o_rd_n, o_wr_n} = {wr, d, 1'b0, wr, !wr};
    for (int i = 0; i < 20 && i_ack_n !== 1'b1; i++) tick(1);
    hung = hung | (i_ack_n !== 1'b1);
    tick(3);
    q = o_bus;
    {drv, o_sel_n, o_rd_n, o_wr_n} = 4'h7;
    tick(1);
  endtask
endmodule

/* verification/hidp_host_port_props.sv */
// Assertions on the host memory DMA port pins
`timescale 1ns/10ps
module hidp_host_port_props
(
  input wire logic i_clk_sys,
  input wire logic i_resetn,
  input wire logic i_host_write_strobe_n,
  input wire logic [2:0] i_boot_mode,
  input wire logic o_muxed_addr_data_bus_oe,
  input wire logic o_host_ack_n,
  input wire logic o_mem_req,
  input wire logic o_mem_we,
  input wire logic o_mem_is_data,
  input wire logic [13:0] o_mem_addr,
  input wire logic o_proc_stall,
  input wire logic o_exec_hold
);
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_resetn);
  // Program word 0 written by the host
  wire logic pm0 = o_mem_req && o_mem_we && !o_mem_is_data && o_mem_addr == 14'h0;
  property p_one; o_mem_req |=> !o_mem_req; endproperty
  a_one: assert property (p_one) else $error("Memory pulse too long");
  property p_stall; o_mem_req |-> o_proc_stall; endproperty
  a_stall: assert property (p_stall) else $error("No stolen cycle");
  property p_ctrl; o_mem_req && o_mem_we && o_mem_is_data |-> o_mem_addr < 14'h3fe0; endproperty
  a_ctrl: assert property (p_ctrl) else $error("Control space written");
  property p_busy; o_mem_req |-> o_host_ack_n && $past(o_host_ack_n); endproperty
  a_busy: assert property (p_busy) else $error("Ready during access");
  property p_hold; $fell(o_exec_hold) |-> pm0 || $past(pm0) || !$past(i_resetn, 2); endproperty
  a_hold: assert property (p_hold) else $error("Hold dropped early");
  property p_boot; $rose(i_resetn) |=> o_exec_hold == ($past(i_boot_mode) == 3'h5); endproperty
  a_boot: assert property (p_boot) else $error("Boot hold wrong");
  property p_rdy; $rose(i_resetn) |=> !o_host_ack_n; endproperty
  a_rdy: assert property (p_rdy) else $error("Not ready after reset");
  property p_oe; o_muxed_addr_data_bus_oe |-> i_host_write_strobe_n; endproperty
  a_oe: assert property (p_oe) else $error("Bus driven during write");
  c_wr: cover property (o_mem_req && o_mem_we);
  c_rd: cover property (o_mem_req && !o_mem_we);
  c_go: cover property ($fell(o_exec_hold));
endmodule
bind hidp_host_port hidp_host_port_props i_hidp_host_port_props (.i_clk_sys(i_clk_sys),
  .i_resetn(i_resetn), .i_host_write_strobe_n(i_host_write_strobe_n),
  .i_boot_mode(i_boot_mode), .o_muxed_addr_data_bus_oe(o_muxed_addr_data_bus_oe),
  .o_host_ack_n(o_host_ack_n), .o_mem_req(o_mem_req), .o_mem_we(o_mem_we),
  .o_mem_is_data(o_mem_is_data), .o_mem_addr(o_mem_addr), .o_proc_stall(o_proc_stall),
  .o_exec_hold(o_exec_hold));

/* verification/hidp_host_port_tb_top.sv */
// Self-checking bench for the host memory DMA port
`timescale 1ns/10ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
  $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module hidp_host_port_tb_top;
  logic clk = 0;
  logic rstn = 0;
  logic sel_n, ale, rd_n, wr_n, oe, ack_n, req, we, isd, stall, hold;
  logic [2:0] boot_mode = 3'h5;
  logic reg_wr = 0;
  logic [13:0] reg_addr = 14'h0;
  logic [13:0] maddr;
  logic [15:0] reg_wdata = 16'h0;
  logic [15:0] bus, dbus, reg_rdata;
  logic [7:0] ovl;
  logic [23:0] wdata;
  wire logic [23:0] rdata = {8'ha5, 2'h0, maddr};
  logic [47:0] lg [64];
  int n = 0;
  int num_errors = 0;
  int checks_done = 0;
  hidp_host_port i_hidp_host_port (.i_clk_sys(clk), .i_resetn(rstn), .i_port_select_n(sel_n),
    .i_addr_latch_strobe(ale), .i_host_read_strobe_n(rd_n), .i_host_write_strobe_n(wr_n),
    .i_muxed_addr_data_bus(bus), .o_muxed_addr_data_bus(dbus), .o_muxed_addr_data_bus_oe(oe),
    .o_host_ack_n(ack_n), .i_boot_mode(boot_mode), .i_dsp_reg_wr(reg_wr),
    .i_dsp_reg_addr(reg_addr),
    .i_dsp_reg_wdata(reg_wdata), .o_dsp_reg_rdata(reg_rdata), .o_mem_req(req), .o_mem_we(we),
    .o_mem_is_data(isd), .o_mem_addr(maddr), .o_mem_overlay(ovl), .o_mem_wdata(wdata),
    .i_mem_rdata(rdata), .o_proc_stall(stall), .o_exec_hold(hold));
  hidp_host_model i_hidp_host_model (.i_clk_sys(clk), .i_ack_n(ack_n), .i_dut_oe(oe),
    .i_dut_bus(dbus), .o_sel_n(sel_n), .o_ale(ale), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_bus(bus));
  // Log every memory pulse
  always @(posedge clk)
    if (req === 1'b1)
    begin
      lg[n] = {ovl, isd, we, maddr, wdata};
      n++;
    end
  task automatic t_dm_write();
    logic [15:0] q;
    int b = n;
    i_hidp_host_model.latch(16'h4100);
    for (int k = 0; k < 3; k++) i_hidp_host_model.xfer(1, 16'(16'hc0de + k), q);
    `CHK(n - b, 3)
    for (int k = 0; k < 3; k++) `CHK(lg[b + k][47:24], {10'h3, 14'(256 + k)})
    for (int k = 0; k < 3; k++) `CHK(lg[b + k][15:0], 16'(16'hc0de + k))
  endtask
  task automatic t_ctrl();
    logic [15:0] q;
    int b = n;
    i_hidp_host_model.latch(16'h7fe0);
    i_hidp_host_model.xfer(1, 16'h1234, q);
    `CHK(n == b || lg[b][38] === 1'b0, 1'b1)
  endtask
  task automatic t_pm_boot();
    logic [15:0] q;
    `CHK(hold, 1'b1)
    i_hidp_host_model.latch(16'h0000);
    i_hidp_host_model.xfer(1, 16'h1234, q);
    i_hidp_host_model.xfer(1, 16'h0056, q);
    `CHK(lg[n - 1], {8'h0, 2'b01, 14'h0, 24'h123456})
    `CHK(hold, 1'b0)
  endtask
  task automatic t_dm_read();
    logic [15:0] q;
    i_hidp_host_model.latch(16'h4200);
    for (int k = 0; k < 2; k++)
    begin
      i_hidp_host_model.xfer(0, 16'h0, q);
      `CHK(q, 16'(16'h0200 + k))
    end
  endtask
  task automatic t_ovl_reg();
    logic [15:0] q;
    i_hidp_host_model.latch(16'h8003);
    {reg_wr, reg_addr, reg_wdata} = {1'b1, 14'h3fe0, 16'h4300};
    @(posedge clk);
    #5;
    {reg_wr, reg_addr} = {1'b0, 14'h3fe7};
    #1;
    `CHK(reg_rdata, 16'h0003)
    i_hidp_host_model.xfer(1, 16'h0bad, q);
    `CHK(lg[n - 1][47:24], {8'h03, 2'b11, 14'h300})
  endtask
  // Mid-run reset with a boot mode that is not host boot
  task automatic t_reset_mode();
    {rstn, boot_mode} = {1'b0, 3'h4};
    #1;
    `CHK({ack_n, hold, oe}, 3'b110)
    repeat (2) @(posedge clk);
    #5;
    rstn = 1;
    repeat (2) @(posedge clk);
    #5;
    `CHK({ack_n, hold}, 2'b00)
    boot_mode = 3'h5;
  endtask
  task automatic results();
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // A handshake that never came ends the run
  always @(posedge i_hidp_host_model.hung)
  begin
    num_errors++;
    results();
  end
  initial
  begin
    forever #25 clk = ~clk;
  end
  initial
  begin
    repeat (2) @(posedge clk);
    #5;
    rstn = 1;
    repeat (2) @(posedge clk);
    #5;
    t_pm_boot();
    t_dm_write();
    t_ctrl();
    t_dm_read();
    t_ovl_reg();
    t_reset_mode();
    t_dm_write();
    results();
  end
endmodule
